// [cfp_core.sv]
// Implementation choices: the Avalon-MM register port and the register addresses.
module cfp_core (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic [15:0] i_code_word,
  input wire logic [7:0] i_port_low_in,
  input wire logic i_ext_wait,
  input wire logic [7:0] i_irq,
  output logic [7:0] o_port_low_out,
  output logic o_port_low_oe,
  output logic [7:0] o_port_high_addr,
  output logic [1:0] o_addr_upper,
  output logic o_ale,
  output logic o_code_fetch_strobe_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_osc_run,
  output logic [31:0] o_pin_special,
  output logic o_src_mode
);

  // ---------------------------------------------------------------
  // input synchronisers (three flops, agree on last two)
  // ---------------------------------------------------------------
  logic [8:0] sy1, sy2, sy3, flt;
  logic [8:0] next_flt;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sy1 <= 9'h000;
      sy2 <= 9'h000;
      sy3 <= 9'h000;
      flt <= 9'h000;
    end else if (i_ce) begin
      sy1 <= {i_ext_wait, i_irq};
      sy2 <= sy1;
      sy3 <= sy2;
      flt <= next_flt;
    end
  end
  // accept a change once second and third stages agree
  always_comb begin
    for (int k = 0; k < 9; k++) begin
      next_flt[k] = (sy2[k] == sy3[k]) ? sy3[k] : flt[k];
    end
  end
  logic ext_wait_s;
  logic [7:0] irq_s;
  assign ext_wait_s = flt[8];
  assign irq_s = flt[7:0];

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // map register number to physical file slot through bank select
  function automatic logic [5:0] rf_slot(input logic [5:0] r,
                                         input logic [1:0] bank);
    if (r < 6'(cfp_pkg::BANK_REGS)) begin
      rf_slot = 6'(({4'h0, bank} << 3) + r);
    end else begin
      rf_slot = 6'(r + 6'(cfp_pkg::BANK_REGS * (cfp_pkg::BANKS - 1)));
    end
  endfunction
  // external address bits kept by configured width
  function automatic logic [17:0] ext_mask(input logic [1:0] aw);
    unique case (aw)
      cfp_pkg::AW17: ext_mask = 18'h1ffff;
      cfp_pkg::AW18: ext_mask = 18'h3ffff;
      default: ext_mask = 18'h0ffff;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // register file: 4 banks of 8 plus 32 upper = 64 slots, 40 visible
  // ---------------------------------------------------------------
  logic [7:0] rf_mem [0:63];

  // ---------------------------------------------------------------
  // software state and bus slave
  // ---------------------------------------------------------------
  logic [31:0] ctrl, pinsel, next_ctrl, next_pinsel;
  logic [7:0] pfw, wake_en, next_pfw, next_wake_en;
  logic [7:0] rf_addr, next_rf_addr;
  logic [23:0] fetch_addr, next_fetch_addr;
  logic fetch_req, next_fetch_req, fetch_kind, next_fetch_kind;
  logic [31:0] rdata, next_rdata;
  logic wreq, next_wreq, wait_q;
  logic idle_m, pdown_m, next_idle_m, next_pdown_m;
  logic [31:0] retired, next_retired;
  logic fetch_busy;
  logic [15:0] fetch_data;
  logic [5:0] slot0;
  logic wr_acc, rd_acc, rf_wr;
  logic wake;

  assign slot0 = rf_slot(rf_addr[5:0], pfw[cfp_pkg::PFW_BANK_LO +: 2]);
  // one wait cycle; read data registered when the request is taken
  // so that it already stands in the answering cycle
  assign wr_acc = i_write && wreq;
  assign rd_acc = i_read && !wreq;
  assign rf_wr = wr_acc && i_address == cfp_pkg::REG_RFDATA
                 && rf_addr < 8'(cfp_pkg::RF_REGS);
  // any enabled request leaves idle or powerdown
  assign wake = |(irq_s & wake_en);

  // next state of the software-visible registers
  always_comb begin
    next_ctrl = ctrl;
    next_pinsel = pinsel;
    next_pfw = pfw;
    next_wake_en = wake_en;
    next_rf_addr = rf_addr;
    next_fetch_addr = fetch_addr;
    next_fetch_req = fetch_req && fetch_busy;
    next_fetch_kind = fetch_kind;
    next_rdata = rdata;
    next_wreq = (i_read || i_write) && !wreq;
    next_idle_m = idle_m;
    next_pdown_m = pdown_m;
    if (wake) begin
      next_idle_m = 1'b0;
      next_pdown_m = 1'b0;
    end
    if (wr_acc) begin
      unique case (i_address)
        cfp_pkg::REG_CTRL: begin
          next_ctrl = i_writedata;
          next_idle_m = i_writedata[cfp_pkg::CTRL_IDLE] && !wake;
          next_pdown_m = i_writedata[cfp_pkg::CTRL_PDOWN] && !wake;
        end
        cfp_pkg::REG_PFW: next_pfw = i_writedata[7:0];
        cfp_pkg::REG_FETCH: begin
          next_fetch_addr = i_writedata[23:0];
          next_fetch_kind = i_writedata[31]; // 1 = data read
          next_fetch_req = 1'b1;
        end
        cfp_pkg::REG_RFADDR: next_rf_addr = i_writedata[7:0];
        cfp_pkg::REG_PINSEL: next_pinsel = i_writedata;
        cfp_pkg::REG_WAKE: next_wake_en = i_writedata[7:0];
        default: ;
      endcase
    end
    if (rd_acc) begin
      unique case (i_address)
        cfp_pkg::REG_CTRL: next_rdata = ctrl;
        cfp_pkg::REG_PFW: next_rdata = {24'h000000, pfw};
        cfp_pkg::REG_FETCH: next_rdata = {8'h00, fetch_addr};
        cfp_pkg::REG_STATUS: next_rdata = {fetch_data, 12'h000,
                                           pdown_m, idle_m,
                                           fetch_busy, fetch_req};
        cfp_pkg::REG_RFADDR: next_rdata = {24'h000000, rf_addr};
        // byte, word or dword view starting at the addressed slot
        cfp_pkg::REG_RFDATA: next_rdata = {
            rf_mem[6'(slot0 + 6'h3)], rf_mem[6'(slot0 + 6'h2)],
            rf_mem[6'(slot0 + 6'h1)], rf_mem[slot0]};
        cfp_pkg::REG_PINSEL: next_rdata = pinsel;
        cfp_pkg::REG_RETIRED: next_rdata = retired;
        cfp_pkg::REG_WAKE: next_rdata = {24'h000000, wake_en};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= cfp_pkg::CTRL_RST;
      pinsel <= cfp_pkg::PINSEL_RST;
      pfw <= cfp_pkg::PFW_RST;
      wake_en <= 8'h00;
      rf_addr <= 8'h00;
      fetch_addr <= 24'h000000;
      fetch_req <= 1'b0;
      fetch_kind <= 1'b0;
      rdata <= 32'h0000_0000;
      wreq <= 1'b0;
      wait_q <= 1'b1;
      idle_m <= 1'b0;
      pdown_m <= 1'b0;
    end else if (i_ce) begin
      ctrl <= next_ctrl;
      pinsel <= next_pinsel;
      pfw <= next_pfw;
      wake_en <= next_wake_en;
      rf_addr <= next_rf_addr;
      fetch_addr <= next_fetch_addr;
      fetch_req <= next_fetch_req;
      fetch_kind <= next_fetch_kind;
      rdata <= next_rdata;
      wreq <= next_wreq;
      wait_q <= !next_wreq; // waitrequest straight from a flop
      idle_m <= next_idle_m;
      pdown_m <= next_pdown_m;
    end
  end

  // register file writes: byte lanes map to consecutive file slots
  // one process only, so the array keeps a single driver
  always_ff @(posedge i_clk) begin
    if (i_ce && rf_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (i_byteenable[b]) begin
          rf_mem[6'(slot0 + 6'(b))] <= i_writedata[8*b +: 8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // fetch and external bus sequencer
  // ---------------------------------------------------------------
  cfp_pkg::cfp_state_e st, next_st;
  logic phase, next_phase; // state phase 1/2
  logic [1:0] strc, next_strc;
  logic [15:0] page_tag, next_page_tag, next_fetch_data;
  logic page_ok, next_page_ok;
  logic [17:0] ext_a;
  logic onchip, hit, cpu_run;
  cfp_pkg::cfp_bus_s bus, next_bus;

  assign cpu_run = !idle_m && !pdown_m;
  assign onchip = fetch_addr >= cfp_pkg::ONCHIP_BASE
                  && fetch_addr <= cfp_pkg::ONCHIP_LIM && !fetch_kind;
  // external reach bounded by width setting, at most 18 bits
  assign ext_a = fetch_addr[17:0]
                 & ext_mask(ctrl[cfp_pkg::CTRL_AW_LO +: 2]);
  assign hit = ctrl[cfp_pkg::CTRL_PAGE] && page_ok && !fetch_kind
               && page_tag == 16'(fetch_addr[23:cfp_pkg::PAGE_BITS]);
  assign fetch_busy = st != cfp_pkg::ST_IDLE;

  // sequencer next state
  always_comb begin
    next_st = st;
    next_phase = ~phase;
    next_strc = strc;
    next_page_tag = page_tag;
    next_page_ok = page_ok;
    next_fetch_data = fetch_data;
    next_retired = retired;
    next_bus = bus;
    next_bus.ale = 1'b0;
    unique case (st)
      cfp_pkg::ST_IDLE: begin
        next_phase = 1'b0;
        if (fetch_req && cpu_run) begin
          if (onchip) begin
            next_st = cfp_pkg::ST_STRT; // one state, 16-bit word
          end else if (hit) begin
            next_st = cfp_pkg::ST_DATA;
            next_bus.code_fetch_strobe_n = 1'b0;
            // page latched already: new low byte rides on the high port
            next_bus.high_out = ext_a[7:0];
            next_bus.low_oe = 1'b0;
          end else begin
            next_st = cfp_pkg::ST_ADDR;
            next_bus.ale = 1'b1;
            next_bus.low_out = ext_a[7:0];
            next_bus.low_oe = 1'b1;
            next_bus.high_out = ext_a[15:8];
            next_bus.upper = ext_a[17:16];
          end
          next_strc = ctrl[cfp_pkg::CTRL_STRETCH +: 2];
        end
      end
      cfp_pkg::ST_ADDR: begin
        next_bus.ale = !phase && ctrl[cfp_pkg::CTRL_ALEEXT];
        if (phase) begin
          next_st = ctrl[cfp_pkg::CTRL_ALEEXT] ? cfp_pkg::ST_ALEX
                                               : cfp_pkg::ST_DATA;
          if (!ctrl[cfp_pkg::CTRL_ALEEXT]) begin
            next_bus.low_oe = 1'b0;
            next_bus.code_fetch_strobe_n = fetch_kind;
            next_bus.rd_n = !fetch_kind;
          end
        end
      end
      cfp_pkg::ST_ALEX: begin
        if (phase) begin
          next_st = cfp_pkg::ST_DATA;
          next_bus.low_oe = 1'b0;
          next_bus.code_fetch_strobe_n = fetch_kind;
          next_bus.rd_n = !fetch_kind;
        end
      end
      cfp_pkg::ST_DATA: begin
        if (phase) begin
          if (strc != 2'h0) begin
            next_strc = strc - 2'h1;
          end else if (!(ctrl[cfp_pkg::CTRL_RTWAIT] && ext_wait_s)) begin
            next_fetch_data = {8'h00, i_port_low_in};
            next_bus.code_fetch_strobe_n = 1'b1;
            next_bus.rd_n = 1'b1;
            // page tag valid only after a code fetch
            next_page_tag = 16'(fetch_addr[23:cfp_pkg::PAGE_BITS]);
            next_page_ok = !fetch_kind;
            next_st = cfp_pkg::ST_DONE;
          end
        end
      end
      cfp_pkg::ST_STRT: begin
        if (phase) begin
          next_fetch_data = i_code_word;
          next_st = cfp_pkg::ST_DONE;
        end
      end
      cfp_pkg::ST_DONE: begin
        next_retired = retired + 32'h1;
        next_st = cfp_pkg::ST_IDLE;
        next_phase = 1'b0;
      end
      default: next_st = cfp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= cfp_pkg::ST_IDLE;
      phase <= 1'b0;
      strc <= 2'h0;
      page_tag <= 16'h0000;
      page_ok <= 1'b0;
      fetch_data <= 16'h0000;
      retired <= 32'h0000_0000;
      bus <= '{low_out: 8'h00, low_oe: 1'b0, high_out: 8'h00,
               upper: 2'h0, ale: 1'b0, code_fetch_strobe_n: 1'b1,
               rd_n: 1'b1, wr_n: 1'b1};
    end else if (i_ce && !pdown_m) begin
      st <= next_st;
      phase <= next_phase;
      strc <= next_strc;
      page_tag <= next_page_tag;
      page_ok <= next_page_ok;
      fetch_data <= next_fetch_data;
      retired <= next_retired;
      bus <= next_bus;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic cpu_en_q, osc_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cpu_en_q <= 1'b1;
      osc_q <= 1'b1;
    end else if (i_ce) begin
      cpu_en_q <= !next_idle_m && !next_pdown_m;
      osc_q <= !next_pdown_m;
    end
  end
  assign o_readdata = rdata;
  assign o_waitrequest = wait_q; // high until the answering cycle
  assign o_port_low_out = bus.low_out;
  assign o_port_low_oe = bus.low_oe;
  assign o_port_high_addr = bus.high_out;
  assign o_addr_upper = bus.upper;
  assign o_ale = bus.ale;
  assign o_code_fetch_strobe_n = bus.code_fetch_strobe_n;
  assign o_rd_n = bus.rd_n;
  assign o_wr_n = bus.wr_n;
  assign o_cpu_clk_en = cpu_en_q;
  assign o_periph_clk_en = osc_q; // peripherals run through idle
  assign o_osc_run = osc_q;
  assign o_pin_special = pinsel;
  assign o_src_mode = ctrl[cfp_pkg::CTRL_SRC];

endmodule : cfp_core

// [cfp_pkg.sv]
package cfp_pkg;

  // ---------------------------------------------------------------
  // bus register map (word offsets as byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // mode control
  localparam logic [7:0] REG_PFW = 8'h04; // program flag word
  localparam logic [7:0] REG_FETCH = 8'h08; // fetch request
  localparam logic [7:0] REG_STATUS = 8'h0c; // core status
  localparam logic [7:0] REG_RFADDR = 8'h10; // register file address
  localparam logic [7:0] REG_RFDATA = 8'h14; // register file data
  localparam logic [7:0] REG_PINSEL = 8'h18; // port pin function select
  localparam logic [7:0] REG_RETIRED = 8'h1c; // retired count
  localparam logic [7:0] REG_WAKE = 8'h20; // wake source enables

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int CTRL_PAGE = 0; // page mode enable
  localparam int CTRL_SRC = 1; // source decode mode
  localparam int CTRL_AW_LO = 2; // address width select, 2 bits
  localparam int CTRL_IDLE = 4; // enter idle
  localparam int CTRL_PDOWN = 5; // enter powerdown
  localparam int CTRL_RTWAIT = 6; // real-time wait enable
  localparam int CTRL_STRETCH = 8; // strobe stretch states, 2 bits
  localparam int CTRL_ALEEXT = 10; // address latch extension
  localparam int PFW_BANK_LO = 3; // bank select field, 2 bits

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] PFW_RST = 8'h00;
  localparam logic [31:0] PINSEL_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------
  localparam int RF_REGS = 40; // register file bytes
  localparam int BANK_REGS = 8; // regs per bank
  localparam int BANKS = 4;
  localparam int LIN_BITS = 24; // linear address width
  localparam int EXT_MAX_BITS = 18; // 256 kbyte reach
  localparam int PAGE_BITS = 8; // 256-byte page
  localparam int CLK_PER_STATE = 2; // two oscillator periods
  localparam logic [1:0] AW16 = 2'h0;
  localparam logic [1:0] AW17 = 2'h1;
  localparam logic [1:0] AW18 = 2'h2;
  localparam logic [23:0] ONCHIP_BASE = 24'hff_0000; // on-chip code
  localparam logic [23:0] ONCHIP_LIM = 24'hff_3fff;

  // fetch/bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ALEX = 3'b010,
    ST_DATA = 3'b011,
    ST_STRT = 3'b100,
    ST_DONE = 3'b101
  } cfp_state_e;

  // external bus pin group
  typedef struct packed {
    logic [7:0] low_out; // port_low_addr_data output
    logic low_oe;
    logic [7:0] high_out; // port_high_addr output
    logic [1:0] upper; // address bits 17:16
    logic ale;
    logic code_fetch_strobe_n;
    logic rd_n;
    logic wr_n;
  } cfp_bus_s;

endpackage : cfp_pkg

// [cfp_core_sva.sv]
// ----------------------------------------
// checker on the core ports
// ----------------------------------------
module cfp_core_sva (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic o_waitrequest,
  input wire logic o_ale,
  input wire logic o_port_low_oe,
  input wire logic o_code_fetch_strobe_n,
  input wire logic o_rd_n,
  input wire logic [7:0] o_port_high_addr,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_osc_run
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // bus answers after exactly one wait cycle
  property p_answer;
    $rose(i_read || i_write) && i_ce |-> o_waitrequest ##1 !o_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("late bus answer");
  property p_once;
    !o_waitrequest |=> o_waitrequest;
  endproperty
  a_once: assert property (p_once) else $error("answer held too long");
  // strobes and address phase
  property p_excl;
    o_rd_n || o_code_fetch_strobe_n;
  endproperty
  a_excl: assert property (p_excl) else $error("two strobes low");
  property p_ale_quiet;
    o_ale |-> o_code_fetch_strobe_n && o_rd_n && o_port_low_oe;
  endproperty
  a_ale_quiet: assert property (p_ale_quiet) else $error("bad addr phase");
  property p_ale_next;
    $fell(o_ale) |-> ##[0:8] !(o_code_fetch_strobe_n && o_rd_n);
  endproperty
  a_ale_next: assert property (p_ale_next) else $error("no data state");
  property p_strobe_end;
    $fell(o_code_fetch_strobe_n) |-> ##[1:200] o_code_fetch_strobe_n;
  endproperty
  a_strobe_end: assert property (p_strobe_end) else $error("strobe stuck");
  // power saving modes
  property p_idle;
    o_osc_run && !o_cpu_clk_en |-> o_periph_clk_en;
  endproperty
  a_idle: assert property (p_idle) else $error("periph clock off");
  property p_pdown;
    !o_osc_run && !$past(o_osc_run) |->
      $stable(o_port_high_addr) && $stable(o_ale);
  endproperty
  a_pdown: assert property (p_pdown) else $error("pins moved");
  c_fetch: cover property ($fell(o_code_fetch_strobe_n));
  c_idle: cover property (o_osc_run && !o_cpu_clk_en);
  c_pdown: cover property (!o_osc_run);
endmodule // cfp_core_sva

// [cfp_ext_mem.sv]
// external memory on the multiplexed bus
module cfp_ext_mem (
  input wire logic i_clk,
  input wire logic i_ale,
  input wire logic [7:0] i_lo,
  input wire logic [7:0] i_hi,
  input wire logic [1:0] i_up,
  input wire logic i_fetch_n,
  input wire logic i_rd_n,
  input wire logic i_slow,
  output logic [7:0] o_data,
  output logic o_wait
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] addr = 18'h0;
  logic [7:0] last = 8'h00;
  logic [2:0] cnt = 3'h0;
  logic fresh = 1'b0;
  logic was_act = 1'b0;
  logic act;
  logic [17:0] a_eff;
  // address latched in the address phase
  always @(posedge i_clk) begin
    if (i_ale) addr <= {i_up, i_hi, i_lo};
    if (act) last <= o_data;
    cnt <= act ? cnt + ((cnt == 3'h7) ? 3'h0 : 3'h1) : 3'h0;
    // a fresh latch serves one strobe; later strobes are page hits
    if (i_ale) fresh <= 1'b1;
    else if (was_act && !act) fresh <= 1'b0;
    was_act <= act;
  end
  // byte while strobed, inverted junk once released
  assign act = !i_fetch_n || !i_rd_n;
  assign a_eff = fresh ? addr : {addr[17:8], i_hi};
  assign o_data = act ? a_eff[7:0] ^ a_eff[15:8] ^ {6'h00, a_eff[17:16]}
                      : ~last;
  assign o_wait = i_slow && act && cnt != 3'h7;
endmodule // cfp_ext_mem

// [tb_cfp_core.sv]
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_cfp_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst_n, i_read, i_write, slow, o_waitrequest, o_ext_wait;
  logic o_port_low_oe, o_ale, o_cs_n, o_rd_n, o_wr_n, o_cpu_clk_en;
  logic o_periph_clk_en, o_osc_run, o_src_mode;
  logic [7:0] i_address, i_irq, i_port_low_in, o_port_low_out;
  logic [7:0] o_port_high_addr, hi_seen;
  logic [1:0] o_addr_upper, up_seen;
  logic [15:0] code_word;
  logic [31:0] i_writedata, o_readdata, o_pin_special, rdata;
  logic [3:0] be;
  int num_errors, total_checks, ale_cnt, c0, n, cs_low, c1;
  cfp_core dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(be),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_code_word(code_word), .i_port_low_in(i_port_low_in),
    .i_ext_wait(o_ext_wait), .i_irq(i_irq),
    .o_port_low_out(o_port_low_out), .o_port_low_oe(o_port_low_oe),
    .o_port_high_addr(o_port_high_addr), .o_addr_upper(o_addr_upper),
    .o_ale(o_ale), .o_code_fetch_strobe_n(o_cs_n), .o_rd_n(o_rd_n),
    .o_wr_n(o_wr_n), .o_cpu_clk_en(o_cpu_clk_en),
    .o_periph_clk_en(o_periph_clk_en), .o_osc_run(o_osc_run),
    .o_pin_special(o_pin_special), .o_src_mode(o_src_mode));
  cfp_ext_mem mem (.i_clk(i_clk), .i_ale(o_ale), .i_lo(o_port_low_out),
    .i_hi(o_port_high_addr), .i_up(o_addr_upper), .i_fetch_n(o_cs_n),
    .i_rd_n(o_rd_n), .i_slow(slow), .o_data(i_port_low_in),
    .o_wait(o_ext_wait));
  // clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // address phase monitor
  always @(posedge i_clk) if (o_ale) begin
    ale_cnt <= ale_cnt + 1;
    up_seen <= o_addr_upper;
    hi_seen <= o_port_high_addr;
  end
  // code strobe low cycles
  always @(posedge i_clk) if (!o_cs_n) cs_low <= cs_low + 1;
  function automatic logic [7:0] eb(input logic [17:0] a);
    return a[7:0] ^ a[15:8] ^ {6'h00, a[17:16]};
  endfunction
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    i_read <= !we;
    i_write <= we;
    i_address <= a;
    i_writedata <= d;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_waitrequest !== 1'b0 && k < 100);
    if (k >= 100) num_errors++;
    rdata = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic fetch(input logic [31:0] cmd);
    int k;
    k = 0;
    bus(1'b1, cfp_pkg::REG_FETCH, cmd);
    do begin
      bus(1'b0, cfp_pkg::REG_STATUS, 32'h0);
      k++;
    end while (rdata[1] !== 1'b0 && k < 60);
    if (k >= 60) num_errors++;
  endtask
  task automatic wait_on(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 40) begin
      @(posedge i_clk);
      n++;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    `CHK(o_pin_special, 32'h0);
    `CHK(o_wr_n, 1'b1);
    bus(1'b0, cfp_pkg::REG_CTRL, 32'h0);
    `CHK(rdata, cfp_pkg::CTRL_RST);
    bus(1'b1, 8'h40, 32'h5a5a5a5a);
    bus(1'b0, 8'h40, 32'h0);
    `CHK(rdata, 32'h0);
  endtask
  task automatic t_fetch;
    c0 = ale_cnt;
    fetch(32'h00ff_0010);
    `CHK(rdata[31:16], code_word);
    `CHK(ale_cnt - c0, 0);
    bus(1'b1, cfp_pkg::REG_CTRL, 32'h1);
    c0 = ale_cnt;
    fetch(32'h0000_1234);
    `CHK(rdata[23:16], eb(18'h01234));
    `CHK(hi_seen, 8'h12);
    `CHK(o_port_low_oe, 1'b0);
    `CHK(ale_cnt > c0, 1'b1);
    c0 = ale_cnt;
    c1 = cs_low;
    fetch(32'h0000_1235);
    `CHK(rdata[23:16], eb(18'h01235));
    `CHK(ale_cnt - c0, 0);
    `CHK(cs_low - c1, 2);
    // real-time wait on top of two stretch states
    bus(1'b1, cfp_pkg::REG_CTRL, 32'h241);
    slow <= 1'b1;
    c1 = cs_low;
    fetch(32'h0000_1236);
    slow <= 1'b0;
    `CHK(rdata[23:16], eb(18'h01236));
    `CHK(cs_low - c1 > 6, 1'b1);
    fetch(32'h8000_1236);
    `CHK(rdata[23:16], eb(18'h01236));
    c0 = ale_cnt;
    fetch(32'h0000_1237);
    `CHK(ale_cnt > c0, 1'b1);
  endtask
  task automatic t_width;
    logic [1:0] up;
    for (int w = 0; w < 3; w++) begin
      up = (w == 0) ? 2'h0 : (w == 1) ? 2'h1 : 2'h3;
      bus(1'b1, cfp_pkg::REG_CTRL, (32'(w) << cfp_pkg::CTRL_AW_LO) | 32'h400);
      fetch(32'h0003_0012);
      `CHK(up_seen, up);
      `CHK(rdata[23:16], eb({up, 16'h0012}));
    end
  endtask
  task automatic t_regs;
    bus(1'b1, cfp_pkg::REG_PFW, 32'h08);
    bus(1'b1, cfp_pkg::REG_RFADDR, 32'h0);
    bus(1'b1, cfp_pkg::REG_RFDATA, 32'ha1);
    bus(1'b1, cfp_pkg::REG_PFW, 32'h10);
    bus(1'b1, cfp_pkg::REG_RFDATA, 32'hb2);
    bus(1'b1, cfp_pkg::REG_PFW, 32'h08);
    bus(1'b0, cfp_pkg::REG_RFDATA, 32'h0);
    `CHK(rdata[7:0], 8'ha1);
    bus(1'b1, cfp_pkg::REG_RFADDR, 32'd36);
    bus(1'b1, cfp_pkg::REG_RFDATA, 32'h44332211);
    bus(1'b0, cfp_pkg::REG_RFDATA, 32'h0);
    `CHK(rdata, 32'h44332211);
    be <= 4'h2;
    bus(1'b1, cfp_pkg::REG_RFDATA, 32'h0000ee00);
    be <= 4'hf;
    bus(1'b0, cfp_pkg::REG_RFDATA, 32'h0);
    `CHK(rdata, 32'h4433ee11);
    bus(1'b1, cfp_pkg::REG_PINSEL, 32'ha5c30f01);
    bus(1'b1, cfp_pkg::REG_CTRL, 32'h2);
    repeat (2) @(posedge i_clk);
    `CHK(o_pin_special, 32'ha5c30f01);
    `CHK(o_src_mode, 1'b1);
  endtask
  task automatic t_power;
    bus(1'b1, cfp_pkg::REG_WAKE, 32'h01);
    bus(1'b1, cfp_pkg::REG_CTRL, 32'h10);
    repeat (3) @(posedge i_clk);
    `CHK(o_cpu_clk_en, 1'b0);
    `CHK(o_periph_clk_en, 1'b1);
    i_irq <= 8'h02;
    repeat (8) @(posedge i_clk);
    `CHK(o_cpu_clk_en, 1'b0);
    i_irq <= 8'h01;
    wait_on(o_cpu_clk_en);
    `CHK(o_cpu_clk_en, 1'b1);
    i_irq <= 8'h00;
    repeat (6) @(posedge i_clk); // let the wake source settle
    bus(1'b1, cfp_pkg::REG_CTRL, 32'h20);
    repeat (3) @(posedge i_clk);
    `CHK(o_osc_run, 1'b0);
    i_irq <= 8'h01;
    wait_on(o_osc_run);
    `CHK(o_osc_run, 1'b1);
    i_irq <= 8'h00;
    repeat (6) @(posedge i_clk);
    bus(1'b1, cfp_pkg::REG_CTRL, 32'h20);
    repeat (3) @(posedge i_clk);
    `CHK(o_osc_run, 1'b0);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    `CHK(o_osc_run, 1'b1);
    i_rst_n <= 1'b1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {i_rst_n, i_read, i_write, slow} = 4'h0;
    {i_address, i_irq, i_writedata} = 48'h0;
    {ale_cnt, cs_low, num_errors, total_checks} = 0;
    be = 4'hf;
    code_word = 16'hbeef;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_fetch();
    t_width();
    t_regs();
    t_power();
    report_and_stop();
  end
  // watchdog
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
endmodule // tb_cfp_core
bind cfp_core cfp_core_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_ce(i_ce), .i_read(i_read), .i_write(i_write),
  .o_waitrequest(o_waitrequest), .o_ale(o_ale),
  .o_port_low_oe(o_port_low_oe), .o_rd_n(o_rd_n),
  .o_code_fetch_strobe_n(o_code_fetch_strobe_n),
  .o_port_high_addr(o_port_high_addr), .o_cpu_clk_en(o_cpu_clk_en),
  .o_periph_clk_en(o_periph_clk_en), .o_osc_run(o_osc_run));
